/* motor_driver_status_regs.sv */
// Purpose: read-only diagnostic status bank of a stepper driver
// Assumes: condition inputs arrive from analog detectors, asynchronous to CORE_CLK
// Notes:   latched flags clear on a one-cycle clear strobe or reset
// Behaviour
// - first word: parity, warning, pump, coil-open flags
// - first word at 04h with fixed bit layout
// - first word flags follow live conditions
// - x-bridge over-current word at 05h
// - y-bridge over-current and shutdown at 06h
// - over-current and shutdown flags are latched
// - live step position word at 07h
// - read-only, RD_DATA zero after reset; the flag words then read 80h (check bit only)
// - pump flag one on charge pump failure
// - over-current flag one on detected over-current
module motor_driver_status_regs
    import status_regs_pkg::*;
(
    // clock and reset
    input  wire logic              CORE_CLK,
    input  wire logic              NRST,
    // detector conditions (asynchronous)
    input  wire supply_cond_t      SUPPLY_COND,
    input  wire bridge_oc_t        X_OC_COND,
    input  wire bridge_oc_t        Y_OC_COND,
    // translator position (same clock)
    input  wire logic [POS_W-1:0]  STEP_POS,
    // read port
    input  wire logic              RD_EN,
    input  wire logic [ADDR_W-1:0] RD_ADDR,
    input  wire logic              LATCH_CLEAR,
    output logic [WORD_W-1:0]      RD_DATA,
    output logic                   RD_VALID
);
    // read timing as the host sees it:
    //   edge n   : RD_EN high, RD_ADDR sampled
    //   edge n+1 : RD_DATA holds the word, RD_VALID high for that cycle
    // the host may keep RD_EN high for back-to-back reads; every edge
    // with RD_EN high is a new read
    // detector levels reach the words two edges after they settle;
    // latched flags need one edge more

    // sizes of the detector bundle and of the sticky flag set
    localparam int SUP_W      = $bits(supply_cond_t);
    localparam int OC_W       = $bits(bridge_oc_t);
    localparam int COND_W     = SUP_W + OC_W + OC_W;
    // both bridges plus the single shutdown flag
    localparam int LATCH_W    = OC_W + OC_W + 1;

    // word slots follow the address map, lowest status address first
    // so the slot index is simply the address minus the base
    localparam int BASE       = int'(ADDR_SUPPLY);
    localparam int NUM_WORDS  = int'(ADDR_STEP) - BASE + 1;
    localparam int IDX_W      = $clog2(NUM_WORDS);
    localparam int IDX_SUPPLY = int'(ADDR_SUPPLY) - BASE;
    localparam int IDX_X      = int'(ADDR_X_BRIDGE) - BASE;
    localparam int IDX_Y      = int'(ADDR_Y_BRIDGE) - BASE;
    localparam int IDX_STEP   = int'(ADDR_STEP) - BASE;

    // detector side: raw lines, two sync stages
    logic [COND_W-1:0]  cond_raw;
    logic [COND_W-1:0]  sync_a;
    logic [COND_W-1:0]  sync_b;
    // synchronised copies
    supply_cond_t       supply_s;
    bridge_oc_t         x_s;
    bridge_oc_t         y_s;

    // sticky flags, one bit per flag, bridges first, shutdown last
    logic [LATCH_W-1:0] latch_set;
    wire  [LATCH_W-1:0] latch_q;
    bridge_oc_t         x_latch;
    bridge_oc_t         y_latch;
    logic               tsd_latch;

    // word assembly and read side
    logic [POS_W-1:0]   payload     [NUM_WORDS];
    wire  [WORD_W-1:0]  status_word [NUM_WORDS];
    logic               addr_hit;
    logic [IDX_W-1:0]   rd_idx;
    logic [WORD_W-1:0]  next_data;
    read_state_t        state;

    // the detectors run off their own analog timing, so every condition
    // line is filtered through two flops before any logic looks at it
    assign cond_raw = {SUPPLY_COND, X_OC_COND, Y_OC_COND};

    // first stage: only the second stage reads it
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            sync_a <= '0;
        end else begin
            sync_a <= cond_raw;
        end
    end

    // second stage: the only copy the rest of the block sees
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            sync_b <= '0;
        end else begin
            sync_b <= sync_a;
        end
    end

    // a condition shorter than one clock may be missed; detectors are
    // expected to hold their levels far longer than that
    assign {supply_s, x_s, y_s} = sync_b;

    // the set term is kept in the clear branch, so an event that lands in
    // the clear cycle survives the clear instead of being lost
    // LATCH_CLEAR is the only way out besides reset: a read never clears,
    // so polling cannot destroy evidence of a fault
    assign latch_set = {x_s, y_s, supply_s.thermal_shutdown_flag};

    generate
        for (genvar i = 0; i < LATCH_W; i++) begin : g_latch
            logic flag;

            always_ff @(posedge CORE_CLK) begin
                if (!NRST) begin
                    flag <= 1'b0;
                end else if (LATCH_CLEAR) begin
                    flag <= latch_set[i];
                end else begin
                    flag <= flag | latch_set[i];
                end
            end

            assign latch_q[i] = flag;
        end
    endgenerate

    assign {x_latch, y_latch, tsd_latch} = latch_q;

    // payload of each word; unused positions stay zero
    always_comb begin
        for (int k = 0; k < NUM_WORDS; k++) begin
            payload[k] = '0;
        end

        // live supply and coil conditions, no latching
        payload[IDX_SUPPLY][BIT_TW]     = supply_s.thermal_warning_flag;
        payload[IDX_SUPPLY][BIT_PUMP]   = supply_s.pump_fault_flag;
        payload[IDX_SUPPLY][BIT_COIL_X] = supply_s.coil_x_break_flag;
        payload[IDX_SUPPLY][BIT_COIL_Y] = supply_s.coil_y_break_flag;

        // latched x-bridge flags, pos high side on the top bit
        payload[IDX_X][BIT_OC_HI:BIT_OC_LO] = x_latch;

        // latched y-bridge flags and shutdown
        payload[IDX_Y][BIT_OC_HI:BIT_OC_LO] = y_latch;
        payload[IDX_Y][BIT_TSD]             = tsd_latch;

        // no synchroniser: the translator shares CORE_CLK
        payload[IDX_STEP] = STEP_POS;
    end

    // one check-bit cell per word, all sharing the package polarity;
    // the bit follows the live payload, so a flag that moves between
    // reads always arrives with a matching check bit
    generate
        for (genvar w = 0; w < NUM_WORDS; w++) begin : g_word
            parity_word u_parity_word (
                .payload (payload[w]),
                .word    (status_word[w])
            );
        end
    endgenerate

    // address decode: only the status slots answer, the rest read zero
    // rd_idx wraps for unmapped addresses, which addr_hit masks out
    // the bank has no write path at all, so every word is read-only
    always_comb begin
        addr_hit  = (RD_ADDR >= ADDR_SUPPLY) && (RD_ADDR <= ADDR_STEP);
        rd_idx    = IDX_W'(RD_ADDR - ADDR_SUPPLY);
        next_data = WORD_RESET;
        if (addr_hit) begin
            next_data = status_word[rd_idx];
        end
    end

    // read data register: loads only on a taken read, so a slow host may
    // sample it at leisure
    // reset leaves it at all zero, which is not a valid check bit pattern;
    // a host must only trust data that followed RD_VALID
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            RD_DATA <= WORD_RESET;
        end else if (RD_EN) begin
            RD_DATA <= next_data;
        end
    end

    // answer tracker: high for the cycle after each taken read
    // one-hot, so a stray code falls back to idle through the default
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            state <= SEL_IDLE;
        end else begin
            case (state)
                SEL_IDLE: begin
                    state <= RD_EN ? SEL_READ : SEL_IDLE;
                end
                SEL_READ: begin
                    state <= RD_EN ? SEL_READ : SEL_IDLE;
                end
                default: begin
                    state <= SEL_IDLE;
                end
            endcase
        end
    end

    // decoded straight from the state register, no extra flop
    assign RD_VALID = (state == SEL_READ);
endmodule

/* status_regs_pkg.sv */
// Purpose: shared constants and carriers for the driver status register bank
// Assumes: 8-bit status words addressed by a 3-bit read index
// Notes:   parity polarity is a package constant shared by all words
package status_regs_pkg;

    localparam int          WORD_W          = 8;
    localparam int          ADDR_W          = 3;
    localparam int          POS_W           = 7;

    localparam logic [2:0]  ADDR_SUPPLY     = 3'h4;
    localparam logic [2:0]  ADDR_X_BRIDGE   = 3'h5;
    localparam logic [2:0]  ADDR_Y_BRIDGE   = 3'h6;
    localparam logic [2:0]  ADDR_STEP       = 3'h7;

    localparam int          BIT_PARITY      = 7;
    localparam int          BIT_TW          = 6;
    localparam int          BIT_PUMP        = 5;
    localparam int          BIT_COIL_X      = 3;
    localparam int          BIT_COIL_Y      = 2;
    localparam int          BIT_OC_HI       = 6;
    localparam int          BIT_OC_LO       = 3;
    localparam int          BIT_TSD         = 2;

    // 1: bit 7 makes the word's count of ones odd
    localparam logic        PARITY_ODD      = 1'b1;

    localparam logic [7:0]  WORD_RESET      = 8'h00;
    localparam logic [3:0]  OC_RESET        = 4'h0;
    localparam logic [6:0]  POS_RESET       = 7'h00;

    // per-bridge over-current order: pos high, pos low, neg high, neg low
    typedef struct packed {
        logic pos_high_side_overcurrent;
        logic pos_low_side_overcurrent;
        logic neg_high_side_overcurrent;
        logic neg_low_side_overcurrent;
    } bridge_oc_t;

    typedef struct packed {
        logic pump_fault_flag;
        logic thermal_warning_flag;
        logic thermal_shutdown_flag;
        logic coil_x_break_flag;
        logic coil_y_break_flag;
    } supply_cond_t;

    typedef enum logic [1:0] {
        SEL_IDLE = 2'b01,
        SEL_READ = 2'b10
    } read_state_t;

endpackage

/* parity_word.sv */
// Purpose: attaches the check bit to a 7-bit status payload
// Assumes: polarity fixed by the package
// Notes:   purely combinational
module parity_word
    import status_regs_pkg::*;
(
    // payload
    input  wire logic [6:0] payload,
    // word with check bit on top
    output logic [7:0]      word
);
    always_comb begin
        word = {(^payload) ^ PARITY_ODD, payload};
    end
endmodule

/* status_regs_chk.sv */
// Purpose: port checks of the status bank
// Assumes: odd parity, answer one cycle after a taken read
// Notes:   bound to the top module
module status_regs_chk
    import status_regs_pkg::*;
(
    // clock and reset
    input wire logic              CORE_CLK,
    input wire logic              NRST,
    // read port
    input wire logic              RD_EN,
    input wire logic [ADDR_W-1:0] RD_ADDR,
    input wire logic              LATCH_CLEAR,
    input wire logic [WORD_W-1:0] RD_DATA,
    input wire logic              RD_VALID,
    // translator position
    input wire logic [POS_W-1:0]  STEP_POS
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    property p_valid; RD_EN |=> RD_VALID; endproperty
    a_valid: assert property (p_valid) else $error("read not answered");
    property p_idle; !RD_EN |=> !RD_VALID && $stable(RD_DATA); endproperty
    a_idle: assert property (p_idle) else $error("output moved without read");
    property p_parity; RD_EN && RD_ADDR[2] |=> ^RD_DATA; endproperty
    a_parity: assert property (p_parity) else $error("bad check bit");
    property p_step; RD_EN && RD_ADDR == ADDR_STEP |=> RD_DATA[6:0] == $past(STEP_POS); endproperty
    a_step: assert property (p_step) else $error("step word wrong");
    property p_unmap; RD_EN && !RD_ADDR[2] |=> RD_DATA == WORD_RESET; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_rst; disable iff (1'b0) !NRST |=> RD_DATA == WORD_RESET && !RD_VALID; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_spare; RD_EN && RD_ADDR == ADDR_SUPPLY |=> !RD_DATA[4] && RD_DATA[1:0] == 2'h0;
    endproperty
    a_spare: assert property (p_spare) else $error("unused supply bits set");
    property p_xspare; RD_EN && RD_ADDR == ADDR_X_BRIDGE |=> RD_DATA[2:0] == 3'h0; endproperty
    a_xspare: assert property (p_xspare) else $error("unused bridge bits set");
    c_clear: cover property (LATCH_CLEAR);
    c_fault: cover property (RD_VALID && RD_DATA[6]);
    c_step: cover property (RD_EN && RD_ADDR == ADDR_STEP);
endmodule

bind motor_driver_status_regs status_regs_chk u_status_regs_chk (.*);

/* status_host.sv */
// Purpose: host model issuing status reads
// Assumes: answer present by the falling edge after the taken edge
// Notes:   address shows inverse when idle
module status_host
    import status_regs_pkg::*;
(
    input wire logic       clk,
    input wire logic [7:0] rd_data,
    input wire logic       rd_valid,
    output logic           rd_en,
    output logic [2:0]     rd_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rd_en = 1'b0;
        rd_addr = 3'h0;
    end
    task automatic read(input logic [2:0] a, output logic [7:0] d);
        @(negedge clk);
        rd_en = 1'b1;
        rd_addr = a;
        @(negedge clk);
        rd_en = 1'b0;
        rd_addr = ~a;
        d = (rd_valid === 1'b1) ? rd_data : 8'hXX;
    endtask
endmodule

/* motor_driver_status_regs_test.sv */
// Purpose: directed reads of the status bank
// Assumes: two-stage input sync, odd parity
// Notes:   inputs change at falling edges
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
    $display("Error t=%0t got %h exp %h", $time, a, e); end end
module motor_driver_status_regs_test
    import status_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, nrst = 0, clr = 0, rd_en, rd_valid;
    supply_cond_t sup = '0;
    bridge_oc_t   xoc = '0, yoc = '0;
    logic [6:0]   step = 7'h00;
    logic [2:0]   rd_addr;
    logic [7:0]   rd_data;
    int           fail_count = 0, num_checks = 0;
    always #5 clk = ~clk;
    motor_driver_status_regs u_motor_driver_status_regs (.CORE_CLK(clk), .NRST(nrst),
        .SUPPLY_COND(sup), .X_OC_COND(xoc), .Y_OC_COND(yoc), .STEP_POS(step),
        .RD_EN(rd_en), .RD_ADDR(rd_addr), .LATCH_CLEAR(clr), .RD_DATA(rd_data),
        .RD_VALID(rd_valid));
    status_host u_status_host (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid),
        .rd_en(rd_en), .rd_addr(rd_addr));
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_status_host.read(a, d);
        `CHK(d, e)
    endtask
    // two sync stages plus the latch edge
    task automatic settle;
        repeat (4) @(negedge clk);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #20000;
        fail_count++;
        finish_test;
    end
    initial begin
        repeat (6) @(negedge clk);
        nrst = 1;
        `CHK(rd_data, 8'h00)
        for (int i = 4; i < 8; i++) rd(3'(i), 8'h80);
        rd(3'h3, 8'h00);
        sup = '1;
        settle;
        rd(ADDR_SUPPLY, 8'hEC);
        sup = 5'h12;
        settle;
        rd(ADDR_SUPPLY, 8'hA8);
        sup = '0;
        settle;
        rd(ADDR_SUPPLY, 8'h80);
        rd(ADDR_Y_BRIDGE, 8'h04);
        $display("supply word done");
        xoc = 4'hA;
        yoc = 4'h5;
        settle;
        xoc = '0;
        yoc = '0;
        settle;
        rd(ADDR_X_BRIDGE, 8'hD0);
        rd(ADDR_Y_BRIDGE, 8'h2C);
        clr = 1;
        @(negedge clk);
        clr = 0;
        rd(ADDR_X_BRIDGE, 8'h80);
        rd(ADDR_Y_BRIDGE, 8'h80);
        yoc = 4'h8;
        @(negedge clk);
        yoc = '0;
        @(negedge clk);
        clr = 1;
        @(negedge clk);
        clr = 0;
        settle;
        rd(ADDR_Y_BRIDGE, 8'h40);
        $display("latch words done");
        step = 7'h7F;
        rd(ADDR_STEP, 8'h7F);
        step = 7'h2A;
        rd(ADDR_STEP, 8'h2A);
        xoc = 4'hF;
        settle;
        nrst = 0;
        xoc = '0;
        repeat (3) @(negedge clk);
        nrst = 1;
        `CHK(rd_data, 8'h00)
        rd(ADDR_X_BRIDGE, 8'h80);
        $display("step and reset done");
        finish_test;
    end
endmodule
